// file: bench/ssp_chk.sv
/* Port-level timing checks for the sync serial port.
   Bound to the port module; sees only its ports, one clock domain. */
`include "ssp_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module ssp_chk (
  // Clock, reset and handshakes
  input wire logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid,
  input wire logic s_axi_rready,
  // Payloads
  input wire logic [1:0] s_axi_bresp, s_axi_rresp,
  input wire logic [`SSP_ADDR_W-1:0] s_axi_araddr,
  input wire logic [31:0] s_axi_rdata,
  // Pins
  input wire logic serial_receive_clock_pin, serial_transmit_data_pin, config_pin_one_oe_n,
  input wire logic config_pin_two_oe_n, change_detect_irq
);
  logic [3:0] since_edge_reg;
  logic clk_seen_reg;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Tx data may only move shortly after the link clock moved
  always_ff @(posedge aclk) begin
    clk_seen_reg <= serial_receive_clock_pin;
    if (!aresetn || clk_seen_reg != serial_receive_clock_pin) since_edge_reg <= 4'h0;
    else if (since_edge_reg != 4'hf) since_edge_reg <= since_edge_reg + 4'h1;
  end
  sequence rd_taken; s_axi_arvalid && s_axi_arready; endsequence
  sequence wr_taken; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  chk_reset_tristate: assert property ($rose(aresetn) |-> config_pin_one_oe_n
    && config_pin_two_oe_n && !change_detect_irq) else $error("pins not tristate after reset");
  chk_rd_answer: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read not answered");
  chk_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped");
  chk_rxd_upper: assert property (rd_taken ##0 s_axi_araddr == `SSP_OFF_RXD |=>
    s_axi_rdata[31:16] == 16'h0 && s_axi_rresp == `SSP_RESP_OKAY) else $error("bad rx word");
  chk_wr_answer: assert property (wr_taken |-> ##[1:3] s_axi_bvalid)
    else $error("write not answered");
  chk_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  chk_tx_on_edge: assert property ($changed(serial_transmit_data_pin) |->
    since_edge_reg < 4'h4 || s_axi_bvalid) else $error("tx data moved without clock");
  chk_irq_clear: assert property ($fell(change_detect_irq) |->
    s_axi_bvalid || $past(s_axi_bvalid)) else $error("irq fell without a write");
endmodule // ssp_chk
bind ssp_sync_serial_port ssp_chk i_chk (.*);
`default_nettype wire

// file: bench/ssp_far_end.sv
/* Far-end codec model: sends receive frames, collects transmit bits.
   Assumes the port samples its link pins on aclk. */
`timescale 1ns/1ps
`default_nettype none
module ssp_far_end (
  // Clock and returned line
  input wire logic aclk, serial_transmit_data_pin,
  // Link toward the port
  output logic serial_receive_clock_pin, receive_frame_sync_pin, serial_receive_data_pin
);
  logic [15:0] got;
  initial {serial_receive_clock_pin, receive_frame_sync_pin, serial_receive_data_pin} = 3'b000;
  // Clock stands low between frames; data idles at the inverse of its last bit
  task automatic send(input logic [15:0] w);
    for (int i = 0; i < 16; i++) begin
      @(posedge aclk);
      receive_frame_sync_pin <= (i == 0);
      serial_receive_data_pin <= w[15-i];
      serial_receive_clock_pin <= 1'b1;
      repeat (4) @(posedge aclk);
      got[15-i] = serial_transmit_data_pin;
      serial_receive_clock_pin <= 1'b0;
      repeat (3) @(posedge aclk);
    end
    receive_frame_sync_pin <= 1'b0;
    serial_receive_data_pin <= ~w[0];
  endtask
endmodule // ssp_far_end
`default_nettype wire

// file: bench/tb.sv
/* Self-checking bench for the sync serial port.
   Assumes the far-end model drives the link and AXI4-Lite reaches the registers. */
`include "ssp_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, q, w;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic serial_receive_clock_pin, receive_frame_sync_pin, serial_receive_data_pin;
  logic serial_transmit_data_pin, config_pin_one_in, config_pin_one_out, config_pin_one_oe_n;
  logic config_pin_two_in, config_pin_two_out, config_pin_two_oe_n, change_detect_irq;
  logic [15:0] rxq[$], txq[$];
  int n_fail, compares, n_hi;
  ssp_sync_serial_port i_dut (.*);
  ssp_far_end i_far (.*);
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  task automatic check(input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Each channel is released at the edge that takes it
  task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
    bit ta, tw, tr, done;
    // One edge between transfers, so no handshake signal is driven twice in one step
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
    {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
    for (int n = 0; n < 40 && !done; n++) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tr = s_axi_arvalid && s_axi_arready;
      done = wr ? s_axi_bvalid : s_axi_rvalid;
      q = s_axi_rdata;
      r = wr ? s_axi_bresp : s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tr) s_axi_arvalid <= 1'b0;
      if (done) {s_axi_bready, s_axi_rready} <= 2'b00;
    end
    if (!done) begin
      n_fail++;
      final_report();
    end
  endtask
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    config_pin_one_in = 1'b0;
    config_pin_two_in = 1'b1;
    w = $urandom(37);
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi(0, `SSP_OFF_CTRL, 0);
    check(q, `SSP_CTRL_RST);
    check({30'h0, config_pin_one_oe_n, config_pin_two_oe_n}, 32'h3);
    axi(0, 8'h14, 0);
    check({30'h0, r}, {30'h0, `SSP_RESP_SLVERR});
    $display("test reset done");
    axi(1, `SSP_OFF_CTRL, 32'h0001e014);
    axi(0, `SSP_OFF_CTRL, 0);
    check(q, 32'h0001e014);
    check({30'h0, config_pin_one_oe_n, config_pin_one_out}, 32'h1);
    w = $urandom();
    axi(1, `SSP_OFF_TXD, w);
    txq = {w[15:0], w[31:16], w[31:16]};
    repeat (3) begin
      rxq.push_back(16'($urandom()));
      i_far.send(rxq[$]);
      check({16'h0, i_far.got}, {16'h0, txq.pop_front()});
    end
    repeat (8) @(posedge aclk);
    axi(0, `SSP_OFF_STAT, 0);
    check(q, 32'h00001bca);
    axi(1, `SSP_OFF_RXACK, 0);
    while (rxq.size() > 0) begin
      axi(0, `SSP_OFF_RXD, 0);
      check(q, {16'h0, rxq.pop_front()});
      axi(1, `SSP_OFF_RXACK, 1);
    end
    $display("test link done");
    axi(1, `SSP_OFF_CTRL, 32'h0001f014);
    axi(0, `SSP_OFF_CTRL, 0);
    check(q, 32'h0001e01f);
    check({30'h0, config_pin_one_oe_n, config_pin_two_oe_n}, 32'h3);
    $display("test soft reset done");
    axi(1, `SSP_OFF_CTRL, 32'h0000004d);
    config_pin_one_in <= 1'b1;
    for (int n = 0; n < 10 && change_detect_irq !== 1'b1; n++) @(posedge aclk);
    check({31'h0, change_detect_irq}, 32'h1);
    axi(0, `SSP_OFF_STAT, 0);
    check(q & 32'h7, 32'h5);
    axi(1, `SSP_OFF_STAT, 32'h4);
    @(posedge aclk);
    check({31'h0, change_detect_irq}, 32'h0);
    $display("test change detect done");
    // Pin one clocks the generator: a one-bit pulse every two words shows on pin two
    axi(1, `SSP_OFF_CTRL, 32'h0000008a);
    for (int n = 0; n < 512; n++) begin
      @(posedge aclk);
      config_pin_one_in <= n[1];
      @(negedge aclk);
      // Window of three whole frames after the clock has settled
      if (n >= 128 && config_pin_two_out === 1'b1) n_hi++;
    end
    check(n_hi, 32'd12);
    check({31'h0, config_pin_two_oe_n}, 32'h0);
    $display("test frame generator done");
    axi(1, `SSP_OFF_CTRL, 32'h0001400f);
    repeat (33) begin
      rxq.push_back(16'($urandom()));
      i_far.send(rxq[$]);
    end
    axi(0, `SSP_OFF_STAT, 0);
    check(q & 32'h0001f810, 32'h00010010);
    axi(0, `SSP_OFF_RXD, 0);
    check(q, {16'h0, rxq[0]});
    $display("test overrun done");
    final_report();
  end
endmodule // tb
`default_nettype wire

// file: common/ssp_defines.svh
/*
  Register offsets, field codes, reset values and sizes for the sync serial port.
  Assumes a 32-bit AXI4-Lite slave with byte addresses of width SSP_ADDR_W.
*/
`ifndef SSP_DEFINES_SVH
`define SSP_DEFINES_SVH

`define SSP_ADDR_W 8
`define SSP_OFF_CTRL 8'h00
`define SSP_OFF_STAT 8'h04
`define SSP_OFF_TXD 8'h08
`define SSP_OFF_RXD 8'h0c
`define SSP_OFF_RXACK 8'h10

`define SSP_MODE_GPO 2'b00
`define SSP_MODE_GPI 2'b01
`define SSP_MODE_ALT 2'b10
`define SSP_MODE_TRI 2'b11

`define SSP_CTRL_RST 32'h0000000f
`define SSP_RESP_OKAY 2'b00
`define SSP_RESP_SLVERR 2'b10

`define SSP_WORD_BITS 16
`define SSP_LAST_BIT 4'hf
`define SSP_RXQ_DEPTH 32
`define SSP_TXQ_DEPTH 30
`define SSP_HALVES_PER_WRITE 2

`endif

// file: common/ssp_pkg.sv
/*
  Types of the sync serial port: control and status layouts, transmitter states.
  Assumes ssp_defines.svh supplies the numeric constants.
*/
package ssp_pkg;

  typedef struct packed {
    logic [11:0] rsvd;
    logic half_order;
    logic rx_fall;
    logic tx_fall;
    logic rx_en;
    logic tx_en;
    logic rx_msb_first;
    logic tx_msb_first;
    logic transmitter_soft_reset;
    logic frame_pulse_length_select;
    logic [3:0] frame_rate_divider_field;
    logic change_detect_irq_enable;
    logic pin_two_output_value;
    logic pin_one_output_value;
    logic [1:0] pin_two_mode_field;
    logic [1:0] pin_one_mode_field;
  } ssp_ctrl_t;

  typedef struct packed {
    logic [14:0] rsvd;
    logic [5:0] rx_count;
    logic [5:0] tx_free;
    logic rx_overrun;
    logic transmit_underrun_flag;
    logic change_seen;
    logic pin_two_input_value;
    logic pin_one_input_value;
  } ssp_stat_t;

  typedef enum logic [1:0] {
    SSP_TX_IDLE = 2'b01,
    SSP_TX_SHIFT = 2'b10
  } ssp_tx_state_t;

endpackage

// file: verilog/ssp_sync_serial_port.sv
/*
  Full-duplex sync serial port with word queues, two configurable pins and a
  frame-sync generator, reached over an AXI4-Lite slave.
  Assumes all serial pins are synchronous to aclk and change at most every other cycle.
*/
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`include "ssp_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module ssp_sync_serial_port import ssp_pkg::*; #(
  parameter int RX_DEPTH = `SSP_RXQ_DEPTH,
  parameter int TX_DEPTH = `SSP_TXQ_DEPTH
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [`SSP_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [`SSP_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial link
  input wire logic serial_receive_clock_pin,
  input wire logic receive_frame_sync_pin,
  input wire logic serial_receive_data_pin,
  output logic serial_transmit_data_pin,
  // Configurable pins
  input wire logic config_pin_one_in,
  output logic config_pin_one_out,
  output logic config_pin_one_oe_n,
  input wire logic config_pin_two_in,
  output logic config_pin_two_out,
  output logic config_pin_two_oe_n,
  // Change detector interrupt
  output logic change_detect_irq
);

  localparam int PW = $clog2(RX_DEPTH);
  localparam int CW = $clog2(RX_DEPTH + 1);
  localparam int HW = `SSP_WORD_BITS;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p, input int depth);
    ptr_inc = (p == PW'(depth - 1)) ? '0 : p + 1'b1;
  endfunction

  function automatic logic clk_edge(input logic prev, input logic now, input logic fall);
    clk_edge = fall ? (prev & ~now) : (~prev & now);
  endfunction

  function automatic logic [HW-1:0] shift_one(input logic [HW-1:0] sr, input logic b,
                                              input logic msb_first);
    shift_one = msb_first ? {sr[HW-2:0], b} : {b, sr[HW-1:1]};
  endfunction

  // Bus side state
  logic aw_held_reg, aw_held_next, w_held_reg, w_held_next;
  logic [`SSP_ADDR_W-1:0] aw_addr_reg, aw_addr_next;
  logic [31:0] w_data_reg, w_data_next, rdata_reg, rdata_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic tx_pend_reg, tx_pend_next;
  logic [HW-1:0] tx_pend_word_reg, tx_pend_word_next;
  logic wr_go, ctrl_wr, tx_push, rx_pop;
  logic [HW-1:0] tx_push_data;
  logic [31:0] w1c;
  logic [CW-1:0] tx_free;
  ssp_stat_t stat_w;

  // Control and flags
  ssp_ctrl_t ctrl_reg, ctrl_next;
  logic soft_rst;
  logic change_seen_reg, change_seen_next, underrun_reg, underrun_next;
  logic overrun_reg, overrun_next, irq_reg, irq_next;
  logic change_set, underrun_set, overrun_set;

  // Receive side
  logic rclk_q_reg, rx_edge, rx_run_reg, rx_run_next, rx_push;
  logic [HW-1:0] rx_sr_reg, rx_sr_next, rx_head;
  logic [3:0] rx_bits_reg, rx_bits_next, rx_idx;
  logic [PW-1:0] rx_wptr_reg, rx_wptr_next, rx_rptr_reg, rx_rptr_next;
  logic [CW-1:0] rx_count_reg, rx_count_next;

  // Transmit side
  ssp_tx_state_t tx_state_reg, tx_state_next;
  logic tclk_q_reg, tclk_src, tx_edge, tx_fs, tx_pop, tx_load;
  logic tx_out_reg, tx_out_next;
  logic [HW-1:0] tx_sr_reg, tx_sr_next, tx_last_reg, tx_last_next, tx_head, tx_word;
  logic [3:0] tx_bits_reg, tx_bits_next;
  logic [PW-1:0] tx_wptr_reg, tx_wptr_next, tx_rptr_reg, tx_rptr_next;
  logic [CW-1:0] tx_count_reg, tx_count_next;

  // Frame generator and pins
  logic [3:0] gen_bits_reg, gen_bits_next, gen_frame_reg, gen_frame_next;
  logic gen_fs_reg, gen_fs_next;
  logic p1_s1_reg, p1_s2_reg, p1_s3_reg, p2_in_reg;
  logic p1_oe_n_reg, p1_oe_n_next, p2_out_reg, p2_out_next, p2_oe_n_reg, p2_oe_n_next;

  // AXI4-Lite slave only; the port issues no bus requests of its own
  assign s_axi_awready = ~aw_held_reg;
  assign s_axi_wready = ~w_held_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  // A pending second halfword holds off the next write so only one push happens per cycle
  assign wr_go = aw_held_reg & w_held_reg & ~bvalid_reg & ~tx_pend_reg;
  // Counts live in the aclk domain, so status needs no crossing
  assign tx_free = CW'(TX_DEPTH) - tx_count_reg;

  always_comb begin
    stat_w = '0;
    stat_w.pin_one_input_value = (ctrl_reg.pin_one_mode_field == `SSP_MODE_GPI) & p1_s2_reg;
    stat_w.pin_two_input_value = (ctrl_reg.pin_two_mode_field == `SSP_MODE_GPI) & p2_in_reg;
    stat_w.change_seen = change_seen_reg;
    stat_w.transmit_underrun_flag = underrun_reg;
    stat_w.rx_overrun = overrun_reg;
    stat_w.tx_free = tx_free;
    stat_w.rx_count = rx_count_reg;
  end

  always_comb begin
    aw_held_next = aw_held_reg;
    aw_addr_next = aw_addr_reg;
    w_held_next = w_held_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg & ~s_axi_bready;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg & ~s_axi_rready;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    tx_pend_next = 1'b0;
    tx_pend_word_next = tx_pend_word_reg;
    tx_push = tx_pend_reg;
    tx_push_data = tx_pend_word_reg;
    rx_pop = 1'b0;
    ctrl_wr = 1'b0;
    w1c = '0;
    if (s_axi_awvalid && !aw_held_reg) begin
      aw_held_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held_reg) begin
      w_held_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (wr_go) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = `SSP_RESP_OKAY;
      case (aw_addr_reg)
        `SSP_OFF_CTRL: ctrl_wr = 1'b1;
        `SSP_OFF_STAT: w1c = w_data_reg;
        `SSP_OFF_TXD: begin
          // Both halves must fit, otherwise the whole word is refused
          if (tx_free >= CW'(`SSP_HALVES_PER_WRITE)) begin
            tx_push = 1'b1;
            tx_pend_next = 1'b1;
            tx_push_data = ctrl_reg.half_order ? w_data_reg[31:16] : w_data_reg[15:0];
            tx_pend_word_next = ctrl_reg.half_order ? w_data_reg[15:0] : w_data_reg[31:16];
          end else begin
            bresp_next = `SSP_RESP_SLVERR;
          end
        end
        `SSP_OFF_RXACK: rx_pop = w_data_reg[0] & (rx_count_reg != '0);
        default: bresp_next = `SSP_RESP_SLVERR;
      endcase
    end
    if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_next = 1'b1;
      rresp_next = `SSP_RESP_OKAY;
      case (s_axi_araddr)
        `SSP_OFF_CTRL: rdata_next = ctrl_reg;
        `SSP_OFF_STAT: rdata_next = stat_w;
        // Reading has no side effect; the word is retired only by the acknowledge
        `SSP_OFF_RXD: rdata_next = {16'h0000, (rx_count_reg != '0) ? rx_head : 16'h0000};
        default: begin
          rdata_next = '0;
          rresp_next = `SSP_RESP_SLVERR;
        end
      endcase
    end
  end

  always_comb begin
    ctrl_next = ctrl_reg;
    soft_rst = 1'b0;
    if (ctrl_wr) begin
      for (int i = 0; i < 4; i++) begin
        if (w_strb_reg[i]) begin
          ctrl_next[i*8 +: 8] = w_data_reg[i*8 +: 8];
        end
      end
      ctrl_next.rsvd = '0;
      if (ctrl_next.transmitter_soft_reset) begin
        soft_rst = 1'b1;
        ctrl_next.pin_one_mode_field = `SSP_MODE_TRI;
        ctrl_next.pin_two_mode_field = `SSP_MODE_TRI;
        ctrl_next.transmitter_soft_reset = 1'b0;
      end
    end
  end

  // Sticky flags: a set in the same cycle as its clear wins
  always_comb begin
    change_set = (ctrl_reg.pin_one_mode_field == `SSP_MODE_GPI) & (p1_s2_reg ^ p1_s3_reg);
    change_seen_next = change_set | (change_seen_reg & ~w1c[2]);
    underrun_next = underrun_set | (underrun_reg & ~w1c[3]);
    overrun_next = overrun_set | (overrun_reg & ~w1c[4]);
    irq_next = change_seen_next & ctrl_next.change_detect_irq_enable;
  end

  // Receive: capture on the far end's clock, realigned by its frame sync
  assign rx_edge = clk_edge(rclk_q_reg, serial_receive_clock_pin, ctrl_reg.rx_fall);
  assign rx_idx = receive_frame_sync_pin ? 4'h0 : rx_bits_reg;

  always_comb begin
    rx_sr_next = rx_sr_reg;
    rx_bits_next = rx_bits_reg;
    rx_run_next = rx_run_reg;
    rx_wptr_next = rx_wptr_reg;
    rx_rptr_next = rx_pop ? ptr_inc(rx_rptr_reg, RX_DEPTH) : rx_rptr_reg;
    rx_push = 1'b0;
    overrun_set = 1'b0;
    if (!ctrl_reg.rx_en) begin
      rx_run_next = 1'b0;
      rx_bits_next = '0;
    end else if (rx_edge && (rx_run_reg || receive_frame_sync_pin)) begin
      rx_run_next = 1'b1;
      rx_sr_next = shift_one(rx_sr_reg, serial_receive_data_pin, ctrl_reg.rx_msb_first);
      rx_bits_next = rx_idx + 1'b1;
      if (rx_idx == `SSP_LAST_BIT) begin
        if (rx_count_reg == CW'(RX_DEPTH)) begin
          overrun_set = 1'b1;
        end else begin
          rx_push = 1'b1;
          rx_wptr_next = ptr_inc(rx_wptr_reg, RX_DEPTH);
        end
      end
    end
    rx_count_next = rx_count_reg + CW'(rx_push) - CW'(rx_pop);
  end

  // Transmit clock and frame sync selection
  always_comb begin
    tclk_src = (ctrl_reg.pin_one_mode_field == `SSP_MODE_ALT) ? config_pin_one_in
                                                              : serial_receive_clock_pin;
    case (ctrl_reg.pin_two_mode_field)
      `SSP_MODE_ALT: tx_fs = gen_fs_reg;
      `SSP_MODE_TRI: tx_fs = config_pin_two_in;
      default: tx_fs = receive_frame_sync_pin;
    endcase
  end

  assign tx_edge = clk_edge(tclk_q_reg, tclk_src, ctrl_reg.tx_fall);

  // Shifts alongside the receiver, sharing its clock unless pin one is ALT and, unless pin two is ALT or TRI, its frame sync
  always_comb begin
    tx_state_next = tx_state_reg;
    tx_sr_next = tx_sr_reg;
    tx_last_next = tx_last_reg;
    tx_bits_next = tx_bits_reg;
    tx_out_next = tx_out_reg;
    tx_wptr_next = tx_push ? ptr_inc(tx_wptr_reg, TX_DEPTH) : tx_wptr_reg;
    tx_load = 1'b0;
    tx_pop = 1'b0;
    underrun_set = 1'b0;
    case (tx_state_reg)
      SSP_TX_IDLE: tx_load = tx_edge & ctrl_reg.tx_en & tx_fs;
      SSP_TX_SHIFT: tx_load = tx_edge & (tx_fs | (tx_bits_reg == 4'h0));
      default: tx_state_next = SSP_TX_IDLE;
    endcase
    tx_word = tx_sr_reg;
    if (tx_load) begin
      tx_state_next = SSP_TX_SHIFT;
      tx_pop = tx_count_reg != '0;
      underrun_set = ~tx_pop;
      tx_word = tx_pop ? tx_head : tx_last_reg;
      tx_last_next = tx_word;
    end
    if (tx_edge && tx_state_next == SSP_TX_SHIFT) begin
      // Send bit 15 or bit 0 first, one bit per active edge
      tx_out_next = ctrl_reg.tx_msb_first ? tx_word[HW-1] : tx_word[0];
      tx_sr_next = shift_one(tx_word, 1'b0, ctrl_reg.tx_msb_first);
      tx_bits_next = tx_load ? 4'h1 : tx_bits_reg + 1'b1;
    end
    tx_rptr_next = tx_pop ? ptr_inc(tx_rptr_reg, TX_DEPTH) : tx_rptr_reg;
    tx_count_next = tx_count_reg + CW'(tx_push) - CW'(tx_pop);
    if (!ctrl_reg.tx_en || soft_rst) begin
      tx_state_next = SSP_TX_IDLE;
      tx_bits_next = '0;
    end
    if (soft_rst) begin
      tx_wptr_next = '0;
      tx_rptr_next = '0;
      tx_count_next = '0;
      tx_out_next = 1'b0;
    end
  end

  // Frame generator: 16 bits per word, divider+1 words per frame
  always_comb begin
    gen_bits_next = gen_bits_reg;
    gen_frame_next = gen_frame_reg;
    gen_fs_next = gen_fs_reg;
    if (soft_rst) begin
      gen_bits_next = '0;
      gen_frame_next = '0;
      gen_fs_next = 1'b0;
    end else if (tx_edge) begin
      gen_bits_next = gen_bits_reg + 1'b1;
      if (gen_bits_reg == `SSP_LAST_BIT) begin
        gen_frame_next = (gen_frame_reg == ctrl_reg.frame_rate_divider_field) ? 4'h0
                                                                              : gen_frame_reg + 1'b1;
      end
      // Word-long pulse covers the first word, bit-long only its first bit
      gen_fs_next = (gen_frame_next == 4'h0) &
                    (ctrl_reg.frame_pulse_length_select | (gen_bits_next == 4'h0));
    end
  end

  // Pin drivers; enables are low while driving
  always_comb begin
    p1_oe_n_next = ctrl_reg.pin_one_mode_field != `SSP_MODE_GPO;
    p2_oe_n_next = (ctrl_reg.pin_two_mode_field != `SSP_MODE_GPO) &
                   (ctrl_reg.pin_two_mode_field != `SSP_MODE_ALT);
    p2_out_next = (ctrl_reg.pin_two_mode_field == `SSP_MODE_ALT) ? gen_fs_reg
                                                                 : ctrl_reg.pin_two_output_value;
  end

  assign config_pin_one_out = ctrl_reg.pin_one_output_value;
  assign config_pin_one_oe_n = p1_oe_n_reg;
  assign config_pin_two_out = p2_out_reg;
  assign config_pin_two_oe_n = p2_oe_n_reg;
  assign serial_transmit_data_pin = tx_out_reg;
  assign change_detect_irq = irq_reg;

  ssp_word_mem #(.WIDTH(HW), .DEPTH(RX_DEPTH), .AW(PW)) u_rx_mem (
    .clk(aclk),
    .we(rx_push),
    .waddr(rx_wptr_reg),
    .wdata(rx_sr_next),
    .raddr(rx_rptr_next),
    .rdata_reg(rx_head)
  );

  ssp_word_mem #(.WIDTH(HW), .DEPTH(TX_DEPTH), .AW(PW)) u_tx_mem (
    .clk(aclk),
    .we(tx_push),
    .waddr(tx_wptr_reg),
    .wdata(tx_push_data),
    .raddr(tx_rptr_next),
    .rdata_reg(tx_head)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_held_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `SSP_RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= `SSP_RESP_OKAY;
      tx_pend_reg <= 1'b0;
      tx_pend_word_reg <= '0;
      ctrl_reg <= `SSP_CTRL_RST;
      change_seen_reg <= 1'b0;
      underrun_reg <= 1'b0;
      overrun_reg <= 1'b0;
      irq_reg <= 1'b0;
      rclk_q_reg <= 1'b0;
      rx_sr_reg <= '0;
      rx_bits_reg <= '0;
      rx_run_reg <= 1'b0;
      rx_wptr_reg <= '0;
      rx_rptr_reg <= '0;
      rx_count_reg <= '0;
      tclk_q_reg <= 1'b0;
      tx_state_reg <= SSP_TX_IDLE;
      tx_sr_reg <= '0;
      tx_last_reg <= '0;
      tx_bits_reg <= '0;
      tx_out_reg <= 1'b0;
      tx_wptr_reg <= '0;
      tx_rptr_reg <= '0;
      tx_count_reg <= '0;
      gen_bits_reg <= '0;
      gen_frame_reg <= '0;
      gen_fs_reg <= 1'b0;
      p1_s1_reg <= 1'b0;
      p1_s2_reg <= 1'b0;
      p1_s3_reg <= 1'b0;
      p2_in_reg <= 1'b0;
      p1_oe_n_reg <= 1'b1;
      p2_out_reg <= 1'b0;
      p2_oe_n_reg <= 1'b1;
    end else begin
      aw_held_reg <= aw_held_next;
      aw_addr_reg <= aw_addr_next;
      w_held_reg <= w_held_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      tx_pend_reg <= tx_pend_next;
      tx_pend_word_reg <= tx_pend_word_next;
      ctrl_reg <= ctrl_next;
      change_seen_reg <= change_seen_next;
      underrun_reg <= underrun_next;
      overrun_reg <= overrun_next;
      irq_reg <= irq_next;
      rclk_q_reg <= serial_receive_clock_pin;
      rx_sr_reg <= rx_sr_next;
      rx_bits_reg <= rx_bits_next;
      rx_run_reg <= rx_run_next;
      rx_wptr_reg <= rx_wptr_next;
      rx_rptr_reg <= rx_rptr_next;
      rx_count_reg <= rx_count_next;
      tclk_q_reg <= tclk_src;
      tx_state_reg <= tx_state_next;
      tx_sr_reg <= tx_sr_next;
      tx_last_reg <= tx_last_next;
      tx_bits_reg <= tx_bits_next;
      tx_out_reg <= tx_out_next;
      tx_wptr_reg <= tx_wptr_next;
      tx_rptr_reg <= tx_rptr_next;
      tx_count_reg <= tx_count_next;
      gen_bits_reg <= gen_bits_next;
      gen_frame_reg <= gen_frame_next;
      gen_fs_reg <= gen_fs_next;
      p1_s1_reg <= config_pin_one_in;
      p1_s2_reg <= p1_s1_reg;
      p1_s3_reg <= p1_s2_reg;
      p2_in_reg <= config_pin_two_in;
      p1_oe_n_reg <= p1_oe_n_next;
      p2_out_reg <= p2_out_next;
      p2_oe_n_reg <= p2_oe_n_next;
    end
  end

endmodule // ssp_sync_serial_port

`default_nettype wire

// file: verilog/ssp_word_mem.sv
/*
  Word memory for one serial queue: one write port, registered read.
  Assumes pointers stay below DEPTH; a write to the address being read is forwarded.
*/
`timescale 1ns/1ps
`default_nettype none

module ssp_word_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  // Clock
  input wire logic clk,
  // Write side
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  // Read side
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata_reg
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] rdata_next;

  always_comb begin
    rdata_next = mem[raddr];
    // Forwarding keeps a word written into an empty queue visible at once
    if (we && (waddr == raddr)) begin
      rdata_next = wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_reg <= rdata_next;
  end

endmodule // ssp_word_mem

`default_nettype wire
